/* File: enc_device.sv */
// Encoder end: serial slave on the link clock plus PWM angle output on mclk.
// Assumes the controller drives chip select and the link clock.
// Operation
// R01: Link is chip select, clock, one data line.
// R02: Every bit uses the shared data line.
// R03: Five command bits then sixteen data, MSB first.
// R04: Extended mode reaches OTP memory only.
// R05: Serial link is default; commands select modes.
// R06: OTP register writable and readable over link.
// R07: Invalid angle holds PWM low.
// R08: Low power refused while PWM output used.
// R09: Code zero high time is one LSB.
// R10: Each code step adds one LSB.
// R11: Period is 257 LSB units.
// R12: High time is position plus one.
// R13: Receiver decodes angle from duty ratio.
// R14: Sample command on rising edge, then turnaround.
// R15: Command zero returns lock, gain, angle, parity.
// R16: Chip select frames transfer; end resets, releases.
// R17: Duty updates only at period boundary.
`timescale 1ns/100ps
module enc_device (
    // Link
    enc_link_if.dev_mp   link,
    // Main clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    // Sensor side
    input  wire logic [7:0] i_angle,
    input  wire logic       i_angle_valid,
    input  wire logic [5:0] i_agc,
    input  wire logic       i_pwm_enable,
    // Outputs
    output logic            o_pwm,
    output logic            o_sleep,
    output logic [15:0]     o_otp
);
    // ==========================================================================
    // Link-clock domain
    typedef struct packed {
        logic [4:0]  bit_cnt;
        logic [4:0]  cmd;
        logic [15:0] shreg;
        logic        oe;
        logic        dout;
    } lk_t;
    // State that must survive the frame reset lives apart from the frame state.
    typedef struct packed {
        logic [15:0] otp;
        logic        sleep;
    } kp_t;
    lk_t lk_ff, nxt_lk;
    kp_t kp_ff, nxt_kp;
    logic [15:0] snap;
    logic [4:0]  cmd_now;
    logic        oe_fall_ff;
    logic [2:0]  ang_s;
    logic [7:0]  ang_l1, ang_l2;
    logic [5:0]  agc_l1, agc_l2;
    logic        lock_l1, lock_l2;
    logic        pwm_l1, pwm_l2;

    // Sensor levels cross into the link domain through two stages.
    always_ff @(posedge link.sclk) begin
        ang_l1  <= i_angle;
        ang_l2  <= ang_l1;
        agc_l1  <= i_agc;
        agc_l2  <= agc_l1;
        lock_l1 <= i_angle_valid;
        lock_l2 <= lock_l1;
        pwm_l1  <= i_pwm_enable;
        pwm_l2  <= pwm_l1;
    end

    always_comb begin
        cmd_now = {lk_ff.cmd[3:0], link.line_di};
        snap = {lock_l2 & ~kp_ff.sleep, agc_l2, ang_l2, ^{lock_l2 & ~kp_ff.sleep, agc_l2, ang_l2}}; // [R15]
        if (cmd_now == enc_link_pkg::CMD_RD_OTP) begin
            snap = kp_ff.otp; // [R06]
        end
    end

    always_comb begin
        nxt_lk = lk_ff;
        nxt_kp = kp_ff;
        if (lk_ff.bit_cnt < 5'(enc_link_pkg::FRAME_BITS)) begin
            nxt_lk.bit_cnt = lk_ff.bit_cnt + 5'h01;
        end
        if (lk_ff.bit_cnt < 5'(enc_link_pkg::CMD_BITS)) begin
            nxt_lk.cmd = {lk_ff.cmd[3:0], link.line_di}; // [R03] [R14]
        end else if (lk_ff.bit_cnt < 5'(enc_link_pkg::FRAME_BITS)) begin
            nxt_lk.shreg = {lk_ff.shreg[14:0], link.line_di}; // [R02]
        end
        if (lk_ff.bit_cnt == 5'(enc_link_pkg::CMD_BITS) - 5'h01) begin
            // Loaded on the last command edge so the first data bit stands before the next rise.
            nxt_lk.oe    = ~lk_ff.cmd[3]; // [R14]
            nxt_lk.shreg = snap;
        end
        if (lk_ff.bit_cnt == 5'(enc_link_pkg::FRAME_BITS) - 5'h01) begin
            if (lk_ff.cmd == enc_link_pkg::CMD_SLEEP) begin
                nxt_kp.sleep = lk_ff.shreg[14] & ~pwm_l2; // [R05] [R08]
            end
            if (lk_ff.cmd == enc_link_pkg::CMD_WR_OTP) begin
                nxt_kp.otp = {lk_ff.shreg[14:0], link.line_di}; // [R04] [R06]
            end
        end
        nxt_lk.dout = nxt_lk.shreg[15];
    end

    // Chip select high acts as the frame reset; the link clock may stop.
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            lk_ff.bit_cnt <= enc_link_pkg::BIT_RESET; // [R16]
            lk_ff.oe      <= 1'b0;
            lk_ff.cmd     <= 5'h00;
            lk_ff.shreg   <= 16'h0000;
            lk_ff.dout    <= 1'b0;
        end else begin
            lk_ff.bit_cnt <= nxt_lk.bit_cnt;
            lk_ff.oe      <= nxt_lk.oe;
            lk_ff.cmd     <= nxt_lk.cmd;
            lk_ff.shreg   <= nxt_lk.shreg;
            lk_ff.dout    <= nxt_lk.dout;
        end
    end

    // The link clock is stopped while reset is released, so the asynchronous clear is safe.
    always_ff @(posedge link.sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            kp_ff <= '0;
        end else begin
            kp_ff <= nxt_kp;
        end
    end

    // Driving starts on the falling edge, the instant the controller lets go.
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            oe_fall_ff <= 1'b0;
        end else begin
            oe_fall_ff <= lk_ff.oe; // [R14]
        end
    end

    assign link.dev_oe = oe_fall_ff & ~link.cs_n; // [R01] [R16]
    assign link.dev_do = lk_ff.dout;

    // ==========================================================================
    // Main-clock domain: PWM generator
    typedef struct packed {
        logic [7:0] div;
        logic [8:0] slot;
        logic [7:0] duty;
        logic       pwm;
        logic [2:0] sl_s;
    } mc_t;
    mc_t mc_ff, nxt_mc;
    logic [1:0] val_s;

    always_comb begin
        nxt_mc = mc_ff;
        nxt_mc.sl_s = {mc_ff.sl_s[1:0], kp_ff.sleep};
        nxt_mc.div  = mc_ff.div + 8'h01;
        if (mc_ff.div == enc_link_pkg::LSB_CYCLES - 8'h01) begin
            nxt_mc.div  = 8'h00;
            nxt_mc.slot = mc_ff.slot + 9'h001;
            if (mc_ff.slot == enc_link_pkg::PWM_PERIOD - 9'h001) begin
                nxt_mc.slot = 9'h000;
                nxt_mc.duty = i_angle; // [R17]
            end
        end
        nxt_mc.pwm = val_s[1] & (nxt_mc.slot <= {1'b0, nxt_mc.duty}); // [R07] [R09] [R10] [R11] [R12]
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mc_ff <= '0;
            val_s <= 2'h0;
        end else begin
            mc_ff <= nxt_mc;
            val_s <= {val_s[0], i_angle_valid};
        end
    end

    assign o_pwm   = mc_ff.pwm;
    assign o_sleep = mc_ff.sl_s[2];
    assign o_otp   = kp_ff.otp;
endmodule : enc_device

/* File: enc_host.sv */
// Controller end: runs one 21-bit transfer per start pulse.
// Assumes the encoder end sits on the same link interface.
`timescale 1ns/100ps
module enc_host (
    // Link
    enc_link_if.host_mp  link,
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    // Request
    input  wire logic        i_start,
    input  wire logic [4:0]  i_cmd,
    input  wire logic [15:0] i_wdata,
    // Answer
    output logic             o_busy,
    output logic             o_done,
    output logic [15:0]      o_rdata
);
    typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, SHIFT = 2'b11, HOLD = 2'b10} st_t;
    typedef struct packed {
        st_t         st;
        logic [3:0]  div;
        logic [4:0]  bit_cnt;
        logic [20:0] tx;
        logic [15:0] rx;
        logic        write;
        logic        sclk;
        logic        cs_n;
        logic        oe;
        logic        done;
        logic [1:0]  di_s;
    } h_t;
    h_t h_ff, nxt_h;
    logic tick;

    always_comb begin
        nxt_h = h_ff;
        nxt_h.done = 1'b0;
        nxt_h.di_s = {h_ff.di_s[0], link.line_di};
        tick = (h_ff.div == enc_link_pkg::SCLK_HALF);
        nxt_h.div = tick ? 4'h0 : h_ff.div + 4'h1;
        case (h_ff.st)
            IDLE: begin
                nxt_h.div = 4'h0;
                if (i_start) begin
                    nxt_h.st      = SETUP;
                    nxt_h.cs_n    = 1'b0; // [R16]
                    nxt_h.tx      = {i_cmd, i_wdata};
                    nxt_h.write   = i_cmd[4];
                    nxt_h.oe      = 1'b1;
                    nxt_h.bit_cnt = 5'h00;
                end
            end
            SETUP: if (tick) begin
                nxt_h.st = SHIFT;
            end
            SHIFT: if (tick) begin
                nxt_h.sclk = ~h_ff.sclk;
                if (h_ff.sclk) begin
                    // Falling edge: present next bit, release after command on reads.
                    nxt_h.tx = {h_ff.tx[19:0], 1'b0}; // [R03]
                    nxt_h.bit_cnt = h_ff.bit_cnt + 5'h01;
                    if (h_ff.bit_cnt == 5'(enc_link_pkg::CMD_BITS) - 5'h01) begin
                        nxt_h.oe = h_ff.write; // [R14]
                    end
                    if (h_ff.bit_cnt == 5'(enc_link_pkg::FRAME_BITS) - 5'h01) begin
                        nxt_h.st = HOLD;
                    end
                end else if (h_ff.bit_cnt >= 5'(enc_link_pkg::CMD_BITS)) begin
                    nxt_h.rx = {h_ff.rx[14:0], h_ff.di_s[1]}; // [R02]
                end
            end
            HOLD: if (tick) begin
                nxt_h.st   = IDLE;
                nxt_h.cs_n = 1'b1; // [R16]
                nxt_h.oe   = 1'b0;
                nxt_h.done = 1'b1;
            end
            default: nxt_h.st = IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            h_ff <= '{st: IDLE, cs_n: 1'b1, default: '0};
        end else begin
            h_ff <= nxt_h;
        end
    end

    assign link.cs_n    = h_ff.cs_n; // [R01]
    assign link.sclk    = h_ff.sclk;
    assign link.host_do = h_ff.tx[20];
    assign link.host_oe = h_ff.oe;
    assign o_busy       = (h_ff.st != IDLE);
    assign o_done       = h_ff.done;
    assign o_rdata      = h_ff.rx;
endmodule : enc_host

/* File: enc_link_if.sv */
// Three-wire link between controller and encoder.
// Assumes the bench resolves the shared data wire from the two enables.
`timescale 1ns/100ps
interface enc_link_if;
    logic cs_n;
    logic sclk;
    logic host_do;
    logic host_oe;
    logic dev_do;
    logic dev_oe;
    logic line_di;
    modport host_mp (output cs_n, output sclk, output host_do, output host_oe, input line_di);
    modport dev_mp  (input cs_n, input sclk, output dev_do, output dev_oe, input line_di);
endinterface : enc_link_if

/* File: enc_link_pkg.sv */
// Shared constants for the encoder serial link and PWM output.
// Assumes both ends are compiled after this package.
package enc_link_pkg;
    // ==========================================================================
    // Serial frame layout
    localparam int         CMD_BITS      = 5;
    localparam int         DATA_BITS     = 16;
    localparam int         FRAME_BITS    = CMD_BITS + DATA_BITS;
    localparam logic [4:0] CMD_RD_ANGLE  = 5'h00;
    localparam logic [4:0] CMD_XT_FIRST  = 5'h1C;
    localparam logic [4:0] CMD_SLEEP     = 5'h11;
    localparam logic [4:0] CMD_WR_OTP    = 5'h1F;
    localparam logic [4:0] CMD_RD_OTP    = 5'h0F;
    // ==========================================================================
    // PWM timing
    localparam real        LSB_NS        = 556.0;
    localparam real        MCLK_NS       = 5.0;
    localparam logic [7:0] LSB_CYCLES    = 8'($rtoi(LSB_NS / MCLK_NS));
    localparam logic [8:0] PWM_PERIOD    = 9'h101;
    // ==========================================================================
    // Host divider: link clock = mclk / (2 * (HALF + 1)).
    localparam logic [3:0] SCLK_HALF     = 4'h3;
    localparam logic [4:0] BIT_RESET     = 5'h00;
endpackage : enc_link_pkg

/* File: enc_link_props.sv */
// Checker for the three-wire link between the controller and encoder ends.
// Assumes the bench instantiates it beside the link interface, on the main clock.
`timescale 1ns/100ps
module enc_link_props (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    // Link
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic host_do,
    input  wire logic host_oe,
    input  wire logic dev_do,
    input  wire logic dev_oe,
    input  wire logic line_di
);
    // ==========================================================================
    // Frame tracking
    logic [4:0] edges_ff;
    logic [4:0] cmd_ff;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // The link clock comes from a divider of the main clock, so its edges are seen whole.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || cs_n) begin
            edges_ff <= 5'h00;
        end else if ($rose(sclk)) begin
            edges_ff <= edges_ff + 5'h01;
            if (edges_ff < 5'h05) begin
                cmd_ff <= {cmd_ff[3:0], line_di};
            end
        end
    end

    sequence s_idle;
        cs_n [*3];
    endsequence
    sequence s_cmd_rise;
        !cs_n && $rose(sclk) && edges_ff < 5'h05;
    endsequence
    sequence s_data_rise;
        !cs_n && $rose(sclk) && edges_ff >= 5'h05;
    endsequence

    // ==========================================================================
    // Assertions
    a_no_drive_fight: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the data line");
    a_idle_clock_low: assert property (s_idle |-> !sclk)
        else $error("link clock moves outside a frame");
    a_start_clock_low: assert property ($fell(cs_n) |-> !sclk [*2])
        else $error("link clock high at frame start");
    a_frame_bit_count: assert property ($rose(cs_n) |-> edges_ff == 5'(enc_link_pkg::FRAME_BITS))
        else $error("frame does not hold 21 clock edges");
    a_end_release: assert property ($rose(cs_n) |-> ##[0:4] (!dev_oe && !host_oe))
        else $error("data line not released after frame");
    a_cmd_host_drive: assert property (s_cmd_rise |-> host_oe && !dev_oe)
        else $error("command bit not driven by controller");
    a_read_dev_drive: assert property (s_data_rise ##0 !cmd_ff[4] |-> dev_oe && !host_oe)
        else $error("read data bit not driven by encoder");
    a_write_host_drive: assert property (s_data_rise ##0 cmd_ff[4] |-> host_oe && !dev_oe)
        else $error("write data bit not driven by controller");
    a_bit_hold: assert property (s_cmd_rise |=> $stable(host_do))
        else $error("command bit changed right after sampling edge");
endmodule : enc_link_props

/* File: encoder_serial_and_pwm_output_bench.sv */
// Bench joining the controller and encoder ends over one link, with a reference model.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
module encoder_serial_and_pwm_output_bench;
    logic        i_mclk   = 1'b0;
    logic        i_resetn = 1'b0;
    logic        start    = 1'b0;
    logic [4:0]  cmd      = 5'h00;
    logic [15:0] wdata    = 16'h0000;
    logic [7:0]  angle    = 8'h00;
    logic [5:0]  agc      = 6'h00;
    logic        valid    = 1'b1;
    logic        pwm_en   = 1'b1;
    logic        last_bit = 1'b0;
    logic        busy, done, pwm, sleep;
    logic [15:0] rdata, otp;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          lsb, h, l;

    enc_link_if lk ();
    // A released line shows the inverse of its last value, so a stale bit never passes.
    assign lk.line_di = lk.host_oe ? lk.host_do : lk.dev_oe ? lk.dev_do : ~last_bit;
    always @(posedge i_mclk) if (lk.host_oe || lk.dev_oe) last_bit <= lk.line_di;

    enc_host u_enc_host (.link(lk.host_mp), .i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(start), .i_cmd(cmd),
        .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata));
    enc_device u_enc_device (.link(lk.dev_mp), .i_mclk(i_mclk), .i_resetn(i_resetn), .i_angle(angle),
        .i_angle_valid(valid), .i_agc(agc), .i_pwm_enable(pwm_en), .o_pwm(pwm), .o_sleep(sleep), .o_otp(otp));
    enc_link_props u_props (.i_mclk(i_mclk), .i_resetn(i_resetn), .cs_n(lk.cs_n), .sclk(lk.sclk),
        .host_do(lk.host_do), .host_oe(lk.host_oe), .dev_do(lk.dev_do), .dev_oe(lk.dev_oe), .line_di(lk.line_di));

    // ==========================================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    function automatic logic [15:0] angle_word(input logic locked);
        logic [14:0] v;
        v = {locked, agc, angle};
        return {v, ^v};
    endfunction : angle_word

    task automatic xfer(input logic [4:0] c, input logic [15:0] w);
        int k = 0;
        @(posedge i_mclk) #1;
        start = 1'b1;
        cmd = c;
        wdata = w;
        @(posedge i_mclk) #1;
        start = 1'b0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge i_mclk) #1;
            k++;
        end
        if (k >= 400) chk(16'h0000, 16'hFFFF);
    endtask : xfer

    task automatic nap(input logic en, input logic [15:0] w, input logic exp);
        pwm_en = en;
        xfer(enc_link_pkg::CMD_SLEEP, w);
        repeat (10) @(posedge i_mclk);
        #1;
        chk(16'(sleep), 16'(exp));
    endtask : nap

    task automatic span(input logic lvl, output int n);
        n = 0;
        while (pwm === lvl && n < 30000) begin
            @(posedge i_mclk) #1;
            n++;
        end
    endtask : span

    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // ==========================================================================
    // Clock, watchdog and main sequence
    initial forever #2.5 i_mclk = ~i_mclk;

    initial begin
        #500000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        h = $urandom(32'h9684);
        lsb = int'(enc_link_pkg::LSB_CYCLES);
        repeat (5) @(posedge i_mclk);
        #1;
        i_resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            angle = 8'($urandom);
            agc = 6'($urandom);
            valid = (i != 2);
            xfer(enc_link_pkg::CMD_RD_ANGLE, 16'h0000);
            chk(rdata, angle_word(valid));
        end
        h = $urandom;
        xfer(enc_link_pkg::CMD_WR_OTP, 16'(h));
        chk(otp, 16'(h));
        xfer(enc_link_pkg::CMD_RD_OTP, 16'h0000);
        chk(rdata, 16'(h));
        nap(1'b1, 16'h8000, 1'b0);
        nap(1'b0, 16'h8000, 1'b1);
        xfer(enc_link_pkg::CMD_RD_ANGLE, 16'h0000);
        chk(rdata, angle_word(1'b0));
        nap(1'b1, 16'h0000, 1'b0);
        angle = 8'hFF;
        span(1'b1, h);
        span(1'b0, h);
        angle = 8'h00;
        span(1'b1, h);
        chk(16'(h), 16'(256 * lsb));
        span(1'b0, l);
        chk(16'(l), 16'(lsb));
        chk(16'(h + l), 16'(257 * lsb));
        chk(16'((257 * h) / (h + l) - 1), 16'h00FF);
        span(1'b1, h);
        chk(16'(h), 16'(lsb));
        valid = 1'b0;
        span(1'b0, l);
        chk(16'(l), 16'(30000));
        stop_test();
    end
endmodule : encoder_serial_and_pwm_output_bench
